/* logic/adcseq_pkg.sv */
// constants, types and behaviour notes for the conversion sequencer
// Notes on behaviour
// - conversion lasts exactly twelve divider periods; on RC the first period is partial
// - three-bit select picks divider or RC clock
// - sequencing ignores channel and direction bits
// - analog pins read zero in port data
// - clearing go bit aborts conversion at once
// - abort leaves result bytes untouched
// - after abort wait two periods, reacquire
// - unit two trigger in mode 1011 starts
// - each trigger in mode 1011 resets the timer counter
// - trigger ignored while converter off, timer reset
// - completion loads result, clears go, sets flag
// - reset clears registers, stops any conversion
package adcseq_pkg;
    // register bus geometry
    localparam int          ADR_W         = 8;
    localparam int          DAT_W         = 32;
    // word-aligned byte offsets
    localparam logic [7:0]  OFS_CTRL0     = 8'h00;
    localparam logic [7:0]  OFS_CTRL1     = 8'h04;
    localparam logic [7:0]  OFS_RES_HI    = 8'h08;
    localparam logic [7:0]  OFS_RES_LO    = 8'h0C;
    localparam logic [7:0]  OFS_FLAGS     = 8'h10;
    localparam logic [7:0]  OFS_ENABLES   = 8'h14;
    localparam logic [7:0]  OFS_PRIO      = 8'h18;
    localparam logic [7:0]  OFS_PORT      = 8'h1C;
    // converter_control_zero fields
    localparam int          CS_LO_LSB     = 6;
    localparam int          CH_LSB        = 3;
    localparam int          GO_BIT        = 2;
    localparam int          ON_BIT        = 0;
    localparam logic [7:0]  CTRL0_WMASK   = 8'hF9;
    // converter_control_one fields
    localparam int          FMT_BIT       = 7;
    localparam int          CS_HI_BIT     = 6;
    localparam logic [7:0]  CTRL1_WMASK   = 8'hCF;
    // peripheral flag position of conversion_done_flag
    localparam int          DONE_BIT      = 6;
    // reset values
    localparam logic [7:0]  CTRL0_RST     = 8'h00;
    localparam logic [7:0]  CTRL1_RST     = 8'h00;
    localparam logic [7:0]  FLAGS_RST     = 8'h00;
    // unit_two_mode_field value that arms the trigger
    localparam logic [3:0]  MODE_TRIGGER  = 4'hB;
    // sequence lengths in bit periods
    localparam logic [3:0]  CONV_TICKS    = 4'hC;
    localparam logic [3:0]  ABORT_TICKS   = 4'h2;
    // clock select low pair that means internal RC
    localparam logic [1:0]  CS_RC         = 2'h3;
    // sequencer states, gray along idle -> convert -> wait
    typedef enum logic [1:0] {
        ADCSEQ_IDLE = 2'b00,
        ADCSEQ_CONV = 2'b01,
        ADCSEQ_WAIT = 2'b11
    } adcseq_state_t;
endpackage

/* logic/adcseq_divider.sv */
// bit-period tick generator: oscillator divider or RC source
`timescale 1ns/1ps
`default_nettype none
module adcseq_divider (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       clear_i,   // restart the period from zero, divider source only
    input  wire logic [2:0] sel_i,     // conv_clock_select
    input  wire logic       rc_tick_i, // one pulse per rising RC edge, synchronised
    output logic            tick_o     // one-cycle pulse per bit period
);
    typedef struct packed {
        logic [5:0] cnt;  // cycles into the current period
        logic       tick; // registered tick
    } adcseq_div_t;

    adcseq_div_t r;
    adcseq_div_t next_r;
    logic [2:0]  shift;   // log2 of period, minus one
    logic [5:0]  last;    // final count of a period

    assign tick_o = r.tick;

    // period is 2 << (2 * low pair + high bit)
    always_comb begin
        next_r = r;
        shift  = {sel_i[1:0], 1'b0} + {2'b00, sel_i[2]};
        last   = 6'((7'h02 << shift) - 7'h01);
        next_r.tick = 1'b0;
        if (sel_i[1:0] == adcseq_pkg::CS_RC) begin
            // rc source: divider stands still, each rising rc edge is a tick
            next_r.cnt  = 6'h00;
            next_r.tick = rc_tick_i;
        end else if (clear_i) begin
            next_r.cnt = 6'h00;
        end else if (r.cnt == last) begin
            next_r.cnt  = 6'h00;
            next_r.tick = 1'b1;
        end else begin
            next_r.cnt = r.cnt + 6'h01;
        end
    end

    // state register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end
endmodule
`default_nettype wire

/* logic/adcseq_sar.sv */
// successive-approximation trial register
`timescale 1ns/1ps
`default_nettype none
module adcseq_sar #(
    parameter int WIDTH = 10
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             start_i, // load the first trial code
    input  wire logic             step_i,  // take one decision
    input  wire logic             cmp_i,   // 1: input at or above trial
    output logic [WIDTH-1:0]      trial_o  // trial code, final result
);
    typedef struct packed {
        logic [WIDTH-1:0] trial; // code under test
        logic [WIDTH-1:0] mask;  // bit being decided
    } adcseq_sar_t;

    adcseq_sar_t r;
    adcseq_sar_t next_r;

    if (WIDTH < 2 || WIDTH > 16) begin : g_width_check
        $error("adcseq_sar: WIDTH must lie in 2..16");
    end

    assign trial_o = r.trial;

    // drop the bit under test when the input is lower, try the next
    always_comb begin
        next_r = r;
        if (start_i) begin
            next_r.mask  = {1'b1, {(WIDTH-1){1'b0}}};
            next_r.trial = {1'b1, {(WIDTH-1){1'b0}}};
        end else if (step_i && (r.mask != '0)) begin
            next_r.trial = (cmp_i ? r.trial : (r.trial & ~r.mask)) | (r.mask >> 1);
            next_r.mask  = r.mask >> 1;
        end
    end

    // state register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end
endmodule
`default_nettype wire

/* logic/adcseq_top.sv */
// conversion sequencer: wishbone registers, state machine, trigger
//
// The implementer's own choices: the address map and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module adcseq_top #(
    parameter int RES_BITS = 10
) (
    input  wire logic                         clk_i,
    input  wire logic                         rst_i,
    // classic wishbone slave
    input  wire logic                         wb_cyc_i,
    input  wire logic                         wb_stb_i,
    input  wire logic                         wb_we_i,
    input  wire logic [adcseq_pkg::ADR_W-1:0] wb_adr_i,
    input  wire logic [3:0]                   wb_sel_i,
    input  wire logic [adcseq_pkg::DAT_W-1:0] wb_dat_i,
    output logic      [adcseq_pkg::DAT_W-1:0] wb_dat_o,
    output logic                              wb_ack_o,
    // analog side and trigger unit
    input  wire logic                         cmp_i,
    input  wire logic                         rc_clk_i,
    input  wire logic [7:0]                   pin_level_i,
    input  wire logic                         trig_i,
    input  wire logic [3:0]                   unit_two_mode_field_i,
    output logic      [9:0]                   dac_o,
    output logic      [2:0]                   channel_select_o,
    output logic                              sample_o,
    output logic                              timer_reset_o,
    output logic                              irq_o
);
    // all flip-flops of the top level
    typedef struct packed {
        logic [7:0]                ctrl0;   // go bit kept as state
        logic [7:0]                ctrl1;
        logic [7:0]                res_hi;
        logic [7:0]                res_lo;
        logic [7:0]                flags;
        logic [7:0]                enables;
        logic [7:0]                prio;
        adcseq_pkg::adcseq_state_t st;
        logic [3:0]                ticks;   // bit periods in state
        logic                      cmp_s1;
        logic                      cmp_s2;
        logic                      rc_s1;
        logic                      rc_s2;
        logic                      rc_s3;   // edge detect on synced rc
        logic [7:0]                pin_s1;
        logic [7:0]                pin_s2;
        logic                      ack;
        logic [31:0]               rdat;
        logic                      irq;
        logic                      samp;
        logic                      tmr_rst;
    } adcseq_top_regs_t;

    adcseq_top_regs_t r;
    adcseq_top_regs_t next_r;

    logic             tick;      // bit-period tick from divider
    logic             div_clear; // restart divider
    logic             sar_start; // load first trial code
    logic             sar_step;  // one decision
    logic [9:0]       sar_code;  // trial code / final result
    logic [2:0]       clk_sel;   // conv_clock_select assembled
    logic             rc_tick;   // rising rc edge, synchronised
    logic             req;       // new bus request this cycle
    logic             wr;        // write to byte lane zero
    logic [7:0]       wbyte;     // written byte
    logic             on;        // converter_on as stored
    logic             trig;      // armed trigger pulse
    logic             go_w;
    logic             on_w;
    logic             abort;
    logic [9:0]       res;
    logic [7:0]       rbyte;

    // twelve periods suit ten bits only
    if (RES_BITS != 10) begin : g_res_check
        $error("adcseq_top: RES_BITS must be 10");
    end

    // analog pins per port_config_field, bit set means analog
    function automatic logic [7:0] analog_mask(input logic [3:0] cfg);
        logic [7:0] m;
        m = 8'h00;
        case (cfg)
            4'h0, 4'h1, 4'h8:      m = 8'hFF;
            4'h2, 4'h3, 4'hC:      m = 8'h1F;
            4'h4, 4'h5:            m = 8'h0B;
            4'h9, 4'hA, 4'hB:      m = 8'h3F;
            4'hD:                  m = 8'h0F;
            4'hE:                  m = 8'h01;
            4'hF:                  m = 8'h0D;
            default:               m = 8'h00;
        endcase
        return m;
    endfunction

    assign wb_dat_o         = r.rdat;
    assign wb_ack_o         = r.ack;
    assign irq_o            = r.irq;
    assign sample_o         = r.samp;
    assign timer_reset_o    = r.tmr_rst;
    assign channel_select_o = r.ctrl0[adcseq_pkg::CH_LSB +: 3];
    assign dac_o            = sar_code;

    assign clk_sel = {r.ctrl1[adcseq_pkg::CS_HI_BIT], r.ctrl0[adcseq_pkg::CS_LO_LSB +: 2]};
    assign on      = r.ctrl0[adcseq_pkg::ON_BIT];
    assign rc_tick = r.rc_s2 & ~r.rc_s3;

    // bit-period clock
    adcseq_divider u_div (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .clear_i   (div_clear),
        .sel_i     (clk_sel),
        .rc_tick_i (rc_tick),
        .tick_o    (tick)
    );

    // comparator decisions use the synchronised comparator
    adcseq_sar #(
        .WIDTH (RES_BITS)
    ) u_sar (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .start_i (sar_start),
        .step_i  (sar_step),
        .cmp_i   (r.cmp_s2),
        .trial_o (sar_code)
    );

    // bus decode, sequencer and interrupt, all in one pass
    always_comb begin
        next_r    = r;
        div_clear = 1'b0;
        sar_start = 1'b0;
        sar_step  = 1'b0;
        abort     = 1'b0;
        go_w      = 1'b0;
        on_w      = 1'b0;
        res       = sar_code;
        rbyte     = 8'h00;
        req       = wb_cyc_i & wb_stb_i & ~r.ack;
        wr        = req & wb_we_i & wb_sel_i[0];
        wbyte     = wb_dat_i[7:0];

        // pins and rc clock come from outside: two flops first
        next_r.cmp_s1 = cmp_i;
        next_r.cmp_s2 = r.cmp_s1;
        next_r.rc_s1  = rc_clk_i;
        next_r.rc_s2  = r.rc_s1;
        next_r.rc_s3  = r.rc_s2;
        next_r.pin_s1 = pin_level_i;
        next_r.pin_s2 = r.pin_s1;

        // ack for one cycle per request, dropped in the next
        next_r.ack     = req;
        next_r.tmr_rst = 1'b0;

        // register writes
        if (wr) begin
            case (wb_adr_i)
                adcseq_pkg::OFS_CTRL0: begin
                    next_r.ctrl0 = wbyte & adcseq_pkg::CTRL0_WMASK;
                    go_w = wbyte[adcseq_pkg::GO_BIT];
                    on_w = wbyte[adcseq_pkg::ON_BIT];
                end
                adcseq_pkg::OFS_CTRL1: begin
                    next_r.ctrl1 = wbyte & adcseq_pkg::CTRL1_WMASK;
                end
                adcseq_pkg::OFS_RES_HI: begin
                    next_r.res_hi = wbyte;
                end
                adcseq_pkg::OFS_RES_LO: begin
                    next_r.res_lo = wbyte;
                end
                adcseq_pkg::OFS_FLAGS: begin
                    // write one to clear; a set below still wins
                    next_r.flags = r.flags & ~wbyte;
                end
                adcseq_pkg::OFS_ENABLES: begin
                    next_r.enables = wbyte;
                end
                adcseq_pkg::OFS_PRIO: begin
                    next_r.prio = wbyte;
                end
                default: begin
                    // unmapped or read-only: write ignored
                end
            endcase
        end

        // special event trigger: timer reset is unconditional
        trig = trig_i & (unit_two_mode_field_i == adcseq_pkg::MODE_TRIGGER);
        if (trig) begin
            next_r.tmr_rst = 1'b1;
        end

        // sequencer; channel and pin direction play no part
        case (r.st)
            adcseq_pkg::ADCSEQ_IDLE: begin
                if (wr && (wb_adr_i == adcseq_pkg::OFS_CTRL0) && go_w && on_w) begin
                    sar_start = 1'b1;
                end else if (trig && on) begin
                    sar_start = 1'b1;
                end
                if (sar_start) begin
                    div_clear    = 1'b1;
                    next_r.ticks = 4'h0;
                    next_r.st    = adcseq_pkg::ADCSEQ_CONV;
                end
            end
            adcseq_pkg::ADCSEQ_CONV: begin
                if (wr && (wb_adr_i == adcseq_pkg::OFS_CTRL0) && !(go_w && on_w)) begin
                    // cleared go: stop now, result bytes left alone
                    abort        = 1'b1;
                    div_clear    = 1'b1;
                    next_r.ticks = 4'h0;
                    next_r.st    = on_w ? adcseq_pkg::ADCSEQ_WAIT : adcseq_pkg::ADCSEQ_IDLE;
                end else if (tick) begin
                    sar_step = (r.ticks < 4'(RES_BITS));
                    if (r.ticks == adcseq_pkg::CONV_TICKS - 4'h1) begin
                        // twelfth period ends: publish and flag
                        next_r.st    = adcseq_pkg::ADCSEQ_IDLE;
                        next_r.ticks = 4'h0;
                        if (r.ctrl1[adcseq_pkg::FMT_BIT]) begin
                            next_r.res_hi = {6'h00, res[9:8]};
                            next_r.res_lo = res[7:0];
                        end else begin
                            next_r.res_hi = res[9:2];
                            next_r.res_lo = {res[1:0], 6'h00};
                        end
                        next_r.flags[adcseq_pkg::DONE_BIT] = 1'b1;
                    end else begin
                        next_r.ticks = r.ticks + 4'h1;
                    end
                end
            end
            adcseq_pkg::ADCSEQ_WAIT: begin
                // hold off sampling two periods, then reacquire alone
                if (wr && (wb_adr_i == adcseq_pkg::OFS_CTRL0) && !on_w) begin
                    next_r.st = adcseq_pkg::ADCSEQ_IDLE;
                end else if (tick) begin
                    if (r.ticks == adcseq_pkg::ABORT_TICKS - 4'h1) begin
                        next_r.st    = adcseq_pkg::ADCSEQ_IDLE;
                        next_r.ticks = 4'h0;
                    end else begin
                        next_r.ticks = r.ticks + 4'h1;
                    end
                end
            end
            default: begin
                next_r.st    = adcseq_pkg::ADCSEQ_IDLE;
                next_r.ticks = 4'h0;
            end
        endcase

        // sampling switch closed while on and idle
        next_r.samp = next_r.ctrl0[adcseq_pkg::ON_BIT] &&
                      (next_r.st == adcseq_pkg::ADCSEQ_IDLE);

        // level interrupt from sticky flags under the mask
        next_r.irq = |(next_r.flags & next_r.enables);

        // read data captured with the ack, zero when unmapped
        case (wb_adr_i)
            adcseq_pkg::OFS_CTRL0: begin
                rbyte = r.ctrl0;
                rbyte[adcseq_pkg::GO_BIT] = (r.st == adcseq_pkg::ADCSEQ_CONV);
            end
            adcseq_pkg::OFS_CTRL1: begin
                rbyte = r.ctrl1;
            end
            adcseq_pkg::OFS_RES_HI: begin
                rbyte = r.res_hi;
            end
            adcseq_pkg::OFS_RES_LO: begin
                rbyte = r.res_lo;
            end
            adcseq_pkg::OFS_FLAGS: begin
                rbyte = r.flags;
            end
            adcseq_pkg::OFS_ENABLES: begin
                rbyte = r.enables;
            end
            adcseq_pkg::OFS_PRIO: begin
                rbyte = r.prio;
            end
            adcseq_pkg::OFS_PORT: begin
                // analog-configured pins always read low
                rbyte = r.pin_s2 & ~analog_mask(r.ctrl1[3:0]);
            end
            default: begin
                rbyte = 8'h00;
            end
        endcase
        if (req && !wb_we_i) begin
            next_r.rdat = {24'h000000, rbyte};
        end
    end

    // one register for the whole state; reset stops everything
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r       <= '0;
            r.ctrl0 <= adcseq_pkg::CTRL0_RST;
            r.ctrl1 <= adcseq_pkg::CTRL1_RST;
            r.flags <= adcseq_pkg::FLAGS_RST;
            r.st    <= adcseq_pkg::ADCSEQ_IDLE;
        end else begin
            r <= next_r;
        end
    end
endmodule
`default_nettype wire

/* tb/adcseq_partner.sv */
// analog side model
`timescale 1ns/1ps
`default_nettype none
module adcseq_partner (
    input  wire logic [9:0] level_i, // level on the channel under test
    input  wire logic [9:0] dac_i,   // trial code from the sequencer
    output logic            cmp_o,   // 1: level at or above trial
    output logic            rc_clk_o // private rc oscillator
);
    logic rc = 1'b0; // rc phase, unrelated to the system clock
    // pin set as input: comparator sees the level
    assign cmp_o = (level_i >= dac_i);
    // free-running rc, 1.6 us bit period
    always #800 rc = ~rc;
    assign rc_clk_o = rc;
endmodule
`default_nettype wire

/* tb/adcseq_checker.sv */
// port assertions of the sequencer
`timescale 1ns/1ps
`default_nettype none
module adcseq_checker (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_ack_o,
    input wire logic [31:0] wb_dat_o,
    input wire logic        trig_i,
    input wire logic [3:0]  unit_two_mode_field_i,
    input wire logic        sample_o,
    input wire logic        timer_reset_o,
    input wire logic        irq_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // armed unit two event
    sequence s_armed;
        trig_i && unit_two_mode_field_i == 4'hB;
    endsequence
    // unanswered request
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    AST_ACK_NEXT: assert property (s_req |=> wb_ack_o)
        else $error("bus ack late");
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    AST_DAT_HOLD: assert property ($changed(wb_dat_o) |-> wb_ack_o)
        else $error("data moved");
    AST_DAT_UPPER: assert property (wb_dat_o[31:8] == 24'h0)
        else $error("upper data set");
    AST_TMR_ARMED: assert property (s_armed |=> timer_reset_o)
        else $error("no timer reset");
    AST_TMR_CAUSE: assert property (timer_reset_o |-> $past(trig_i && unit_two_mode_field_i == 4'hB))
        else $error("stray timer reset");
    AST_TRIG_START: assert property (s_armed ##0 sample_o |-> ##[1:2] !sample_o)
        else $error("trigger ignored");
    // reset itself must silence outputs
    AST_RESET_QUIET: assert property (disable iff (1'b0) rst_i |=> !irq_o && !sample_o && !timer_reset_o && !wb_ack_o)
        else $error("outputs after reset");
    cover property (s_armed ##0 sample_o);
endmodule
`default_nettype wire
bind adcseq_top adcseq_checker u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .trig_i(trig_i),
    .unit_two_mode_field_i(unit_two_mode_field_i), .sample_o(sample_o),
    .timer_reset_o(timer_reset_o), .irq_o(irq_o));

/* tb/testbench.sv */
// self-checking sequencer bench
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        clk_i = 1'b0;  // 100 MHz system clock
    logic        rst_i = 1'b1;  // sync reset, high
    logic [41:0] req   = 42'h0; // cyc+stb, we, adr, dat
    logic        trig  = 1'b0;  // unit two event pulse
    logic [3:0]  mode2 = 4'h0;  // unit two mode
    logic [7:0]  pins  = 8'hC3; // port pin levels
    logic [9:0]  level = 10'h0; // analog level
    logic [31:0] wb_dat_o;
    logic        wb_ack_o, cmp, rc, sample_o, timer_reset_o, irq_o;
    logic [9:0]  dac;
    logic [2:0]  chs;
    int          mismatches = 0, samples_checked = 0, cycles = 0;
    logic [2:0]  codes [7] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3};
    int          divs [7]  = '{2, 4, 8, 16, 32, 64, 0}; // 0: rc source
    adcseq_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req[41]), .wb_stb_i(req[41]),
        .wb_we_i(req[40]), .wb_adr_i(req[39:32]), .wb_sel_i(4'hF), .wb_dat_i(req[31:0]),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cmp_i(cmp), .rc_clk_i(rc),
        .pin_level_i(pins), .trig_i(trig), .unit_two_mode_field_i(mode2), .dac_o(dac),
        .channel_select_o(chs), .sample_o(sample_o), .timer_reset_o(timer_reset_o),
        .irq_o(irq_o));
    adcseq_partner u_far (.level_i(level), .dac_i(dac), .cmp_o(cmp), .rc_clk_o(rc));
    always #5 clk_i = ~clk_i;
    // hang guard
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 30000) begin
            mismatches++;
            complete_run();
        end
    end
    task automatic complete_run();
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    // classic cycle, released at the ack edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] q);
        int n = 0;
        @(posedge clk_i);
        req <= {1'b1, w, a, 24'h0, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        check("bus ack", 1'b1, wb_ack_o);
        q = wb_dat_o[7:0];
        req <= 42'h0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        xfer(1'b1, a, d, q);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp, input string what);
        logic [7:0] q;
        xfer(1'b0, a, 8'h00, q);
        check(what, exp, q);
    endtask
    task automatic wait_irq(output int n);
        n = 0;
        do begin
            @(posedge clk_i);
            #1 n++;
        end while (irq_o !== 1'b1 && n < 2500);
    endtask
    task automatic do_reset();
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
    endtask
    // reset values and access kinds
    task automatic t_regs();
        logic [7:0] ofs [7] = '{adcseq_pkg::OFS_CTRL0, adcseq_pkg::OFS_CTRL1,
            adcseq_pkg::OFS_FLAGS, adcseq_pkg::OFS_ENABLES, adcseq_pkg::OFS_PRIO,
            adcseq_pkg::OFS_RES_HI, adcseq_pkg::OFS_RES_LO};
        for (int i = 0; i < 7; i++)
            rdc(ofs[i], 8'h00, "reset value");
        check("irq after reset", 1'b0, irq_o);
        wr(adcseq_pkg::OFS_CTRL1, 8'hFF);
        rdc(adcseq_pkg::OFS_CTRL1, 8'hCF, "ctrl1 reserved bits");
        wr(adcseq_pkg::OFS_CTRL1, 8'h00);
        wr(adcseq_pkg::OFS_PRIO, 8'hA5);
        rdc(adcseq_pkg::OFS_PRIO, 8'hA5, "priority storage");
        wr(8'h20, 8'hFF);
        rdc(8'h20, 8'h00, "unmapped read");
        $display("test registers done");
    endtask
    // analog pins read low
    task automatic t_port();
        rdc(adcseq_pkg::OFS_PORT, 8'h00, "port all analog");
        wr(adcseq_pkg::OFS_CTRL1, 8'h06);
        rdc(adcseq_pkg::OFS_PORT, 8'hC3, "port all digital");
        wr(adcseq_pkg::OFS_CTRL1, 8'h0E);
        rdc(adcseq_pkg::OFS_PORT, 8'hC2, "port one analog");
        $display("test port done");
    endtask
    // one conversion per select code 0 to 6, timed on divider codes
    task automatic t_conv(input logic [2:0] cs, input int div, input logic fmt,
                          input logic [2:0] ch);
        int n;
        level = 10'h2B5 + 10'(div);
        wr(adcseq_pkg::OFS_CTRL1, {fmt, cs[2], 6'h00});
        wr(adcseq_pkg::OFS_CTRL0, {cs[1:0], ch, 3'h1});
        check("channel out", ch, chs);
        repeat (130) @(posedge clk_i);
        wr(adcseq_pkg::OFS_CTRL0, {cs[1:0], ch, 3'h5});
        wait_irq(n);
        if (div > 0)
            check("conv time", 1'b1, n == 12 * div || n == 12 * div + 1);
        check("irq at done", 1'b1, irq_o);
        // divide 2: comparator one decision stale
        if (div != 2) begin
            rdc(adcseq_pkg::OFS_RES_HI, fmt ? {6'h00, level[9:8]} : level[9:2], "res hi");
            rdc(adcseq_pkg::OFS_RES_LO, fmt ? level[7:0] : {level[1:0], 6'h00}, "res lo");
        end
        rdc(adcseq_pkg::OFS_CTRL0, {cs[1:0], ch, 3'h1}, "go cleared");
        rdc(adcseq_pkg::OFS_FLAGS, 8'h40, "done flag");
        wr(adcseq_pkg::OFS_ENABLES, 8'h00);
        check("irq masked", 1'b0, irq_o);
        wr(adcseq_pkg::OFS_ENABLES, 8'h40);
        check("irq unmasked", 1'b1, irq_o);
        wr(adcseq_pkg::OFS_FLAGS, 8'h40);
        rdc(adcseq_pkg::OFS_FLAGS, 8'h00, "flag cleared");
        check("irq cleared", 1'b0, irq_o);
        $display("test conversion code %0d done", cs);
    endtask
    // abort keeps results, reacquires after two periods
    task automatic t_abort();
        int n = 0;
        wr(adcseq_pkg::OFS_CTRL1, 8'h80);
        wr(adcseq_pkg::OFS_RES_HI, 8'h02);
        wr(adcseq_pkg::OFS_RES_LO, 8'h5A);
        wr(adcseq_pkg::OFS_CTRL0, 8'h49);
        repeat (130) @(posedge clk_i);
        wr(adcseq_pkg::OFS_CTRL0, 8'h4D);
        repeat (30) @(posedge clk_i);
        wr(adcseq_pkg::OFS_CTRL0, 8'h49);
        do begin
            @(posedge clk_i);
            #1 n++;
        end while (sample_o !== 1'b1 && n < 40);
        check("abort wait", 1'b1, n >= 15 && n <= 17);
        rdc(adcseq_pkg::OFS_RES_HI, 8'h02, "res hi kept");
        rdc(adcseq_pkg::OFS_RES_LO, 8'h5A, "res lo kept");
        rdc(adcseq_pkg::OFS_FLAGS, 8'h00, "no flag on abort");
        rdc(adcseq_pkg::OFS_CTRL0, 8'h49, "go after abort");
        $display("test abort done");
    endtask
    // unit two event: armed and on starts
    task automatic t_trig(input logic [3:0] m, input logic on);
        int n;
        logic go = on && m == 4'hB;
        wr(adcseq_pkg::OFS_CTRL0, {5'h0A, 2'b00, on});
        repeat (130) @(posedge clk_i);
        trig <= 1'b1;
        mode2 <= m;
        @(posedge clk_i);
        trig <= 1'b0;
        #1 check("timer reset", m == 4'hB, timer_reset_o);
        wait_irq(n);
        check("trigger start", go, irq_o);
        if (go)
            wr(adcseq_pkg::OFS_FLAGS, 8'h40);
        $display("test trigger mode %0d on %0d done", m, on);
    endtask
    initial begin
        do_reset();
        t_regs();
        t_port();
        wr(adcseq_pkg::OFS_ENABLES, 8'h40);
        for (int i = 0; i < 7; i++)
            t_conv(codes[i], divs[i], i[0], i[2:0]);
        t_abort();
        t_trig(4'hB, 1'b1);
        t_trig(4'hB, 1'b0);
        t_trig(4'h3, 1'b1);
        // mid-conversion reset
        wr(adcseq_pkg::OFS_CTRL0, 8'h51);
        wr(adcseq_pkg::OFS_CTRL0, 8'h55);
        repeat (40) @(posedge clk_i);
        do_reset();
        t_regs();
        complete_run();
    end
endmodule
`default_nettype wire
